// file: pkg/e1_alarm_pkg.sv
// constants, register map and field layout of the e1 interface alarm monitor
// assumes one 40 MHz core clock and a plain strobe register port
`default_nettype none
package e1_alarm_pkg;
   localparam int unsigned CLK_HZ         = 40_000_000;
   localparam int unsigned SEC_CYCLES     = CLK_HZ;
   localparam logic [13:0] IDLE_MAX_SEC   = 14'h270F;
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_ROUTE       = 8'h00;
   localparam logic [7:0] OFF_TX_IDLE     = 8'h04;
   localparam logic [7:0] OFF_RX_IDLE     = 8'h08;
   localparam logic [7:0] OFF_CTRL        = 8'h0C;
   localparam logic [7:0] OFF_STATUS      = 8'h10;
   localparam logic [7:0] OFF_BUF0        = 8'h14;
   localparam logic [7:0] OFF_BUF1        = 8'h18;
   localparam logic [7:0] OFF_BPV0        = 8'h1C;
   localparam logic [7:0] OFF_BPV1        = 8'h20;
   localparam logic [7:0] OFF_CRC0        = 8'h24;
   localparam logic [7:0] OFF_CRC1        = 8'h28;
   localparam logic [7:0] OFF_CMD         = 8'h2C;
   localparam logic [7:0] OFF_ID          = 8'h30;
   // route register fields
   localparam int unsigned F_IO_ROUTE     = 0;   // 3 bits
   localparam int unsigned F_TXD_ROUTE    = 4;   // 2 bits
   localparam int unsigned F_RXD_ROUTE    = 6;
   localparam int unsigned F_TEST_ROUTE   = 8;
   localparam int unsigned F_HW_ROUTE     = 10;
   localparam int unsigned F_HW_NOTIFY    = 12;  // 2 bits
   // control register fields
   localparam int unsigned F_SAT_LOOP     = 0;
   localparam int unsigned F_TER_LOOP     = 1;
   localparam int unsigned F_CODING       = 2;
   // command register fields (write one)
   localparam int unsigned F_CLR_BPV      = 0;   // 2 bits, one per port
   localparam int unsigned F_CLR_CRC      = 2;
   localparam int unsigned F_RECENTRE     = 4;
   localparam logic [31:0] ROUTE_RESET    = 32'h0000_0000;
   localparam logic [13:0] IDLE_RESET     = 14'h001E;
   localparam logic [31:0] BLOCK_ID       = 32'h0000_0A11; // arbitrary value
   localparam int unsigned BUF_DEPTH      = 64;
   localparam logic [6:0]  BUF_CENTRE     = 7'h20;
   localparam logic [7:0]  PCT_CENTRE     = 8'h64;
   // line coding choices
   typedef enum logic {CODE_AMI = 1'b0, CODE_HDB3 = 1'b1} coding_t;
endpackage
`default_nettype wire

// file: logic/idle_timer.sv
// idle supervision timer: counts whole seconds without activity
// assumes a one-cycle second tick from the parent divider
`default_nettype none
module idle_timer
   import e1_alarm_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        sec_tick_in,
   input  wire logic        activity_in,
   input  wire logic [13:0] limit_in,
   output logic             alarm_out
);
   logic [13:0] secs_q;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         secs_q <= 14'h0000;
      end else if (activity_in || limit_in == 14'h0000) begin
         secs_q <= 14'h0000;
      end else if (sec_tick_in && secs_q != limit_in) begin
         secs_q <= secs_q + 14'h0001;
      end
   end

   // zero limit disables the alarm entirely
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         alarm_out <= 1'b0;
      end else begin
         alarm_out <= (limit_in != 14'h0000) && !activity_in && (secs_q >= limit_in);
      end
   end
endmodule
`default_nettype wire

// file: logic/e1_alarm_monitor.sv
// e1 interface alarm routing, idle supervision, loopback, coding and error counters
// assumes synchronous inputs, one 40 MHz clock, strobe register port
// Function
// R01 - io alarm route 0..7: bits select A, B; values 4..7 also mute carrier
// R02 - send data, test, hardware alarms: 0 none, 1 A, 2 B, 3 both
// R03 - receive data alarm uses the same two-bit routing
// R04 - send data alarm after programmed idle seconds; zero disables
// R05 - receive data alarm after programmed idle seconds; zero disables
// R06 - satellite loopback feeds receive output back into send input
// R07 - terrestrial loopback returns line send input to line receive output
// R08 - report buffer fill percent (100 centred) and slips; recentre on command
// R09 - per-port bipolar violation counts, cleared by command
// R10 - per-port crc error counts, cleared by command
// R11 - report handshake line states while auxiliary channel active
// R12 - port 1 send coding: 0 AMI, 1 HDB3
// R13 - hardware alarm notify: 1 log only, 2 log and alert
// R14 - alarm outputs OR routed sources; mute held while muting alarm active
//
// Design decisions made here: the address map and the address-and-strobe port.
`default_nettype none
module e1_alarm_monitor
   import e1_alarm_pkg::*;
(
   // clock and reset
   input  wire logic        CORE_CLK_IN,
   input  wire logic        RESET_N_IN,
   // register port
   input  wire logic [7:0]  REG_ADDR_IN,
   input  wire logic [31:0] REG_WDATA_IN,
   input  wire logic        REG_WR_IN,
   input  wire logic        REG_RD_IN,
   output logic [31:0]      REG_RDATA_OUT,
   // alarm sources
   input  wire logic        IO_ALARM_IN,
   input  wire logic        TEST_ACTIVE_IN,
   input  wire logic        HW_ALARM_IN,
   // activity and error events
   input  wire logic        TX_ACTIVITY_IN,
   input  wire logic        RX_ACTIVITY_IN,
   input  wire logic [1:0]  BIPOLAR_VIOLATION_IN,
   input  wire logic [1:0]  CRC_ERROR_IN,
   // receive buffer per port: write and read of one entry
   input  wire logic [1:0]  BUF_WR_IN,
   input  wire logic [1:0]  BUF_RD_IN,
   input  wire logic [1:0]  BUF_ACTIVE_IN,
   // data path
   input  wire logic        LINE_SEND_IN,
   input  wire logic        SAT_RCV_IN,
   output logic             SAT_SEND_OUT,
   output logic             LINE_RCV_OUT,
   output logic             CODING_HDB3_OUT,
   // auxiliary serial channel handshake: rts cts dcd dtr dsr
   input  wire logic        AUXILIARY_SERIAL_CHANNEL_ACTIVE_IN,
   input  wire logic [4:0]  HANDSHAKE_IN,
   // alarm outputs
   output logic             ALARM_A_OUT,
   output logic             ALARM_B_OUT,
   output logic             CARRIER_OUTPUT_MUTE_OUT,
   output logic             HW_LOG_OUT,
   output logic             HW_ALERT_OUT
);
   logic [31:0] route_q;
   logic [13:0] tx_idle_q;
   logic [13:0] rx_idle_q;
   logic [2:0]  ctrl_q;
   logic [25:0] div_q;
   logic        sec_tick_q;
   logic        tx_alarm;
   logic        rx_alarm;
   logic        hw_prev_q;
   logic [4:0]  hs_q;
   logic [15:0] bpv_q [2];
   logic [15:0] crc_q [2];
   logic [6:0]  fill_q [2];
   logic [15:0] slip_q [2];
   logic [5:0]  cmd;
   logic        wr_cmd;

   assign wr_cmd = REG_WR_IN && REG_ADDR_IN == OFF_CMD;
   assign cmd    = wr_cmd ? REG_WDATA_IN[5:0] : 6'h00;

   // configuration writes
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         route_q   <= ROUTE_RESET;
         tx_idle_q <= IDLE_RESET;
         rx_idle_q <= IDLE_RESET;
         ctrl_q    <= 3'h0;
      end else if (REG_WR_IN) begin
         if (REG_ADDR_IN == OFF_ROUTE) begin
            route_q <= {18'h0_0000, REG_WDATA_IN[13:0]};
         end else if (REG_ADDR_IN == OFF_TX_IDLE) begin
            // values above the documented range saturate
            tx_idle_q <= (REG_WDATA_IN[13:0] > IDLE_MAX_SEC) ? IDLE_MAX_SEC
                         : REG_WDATA_IN[13:0]; // [R04]
         end else if (REG_ADDR_IN == OFF_RX_IDLE) begin
            rx_idle_q <= (REG_WDATA_IN[13:0] > IDLE_MAX_SEC) ? IDLE_MAX_SEC
                         : REG_WDATA_IN[13:0]; // [R05]
         end else if (REG_ADDR_IN == OFF_CTRL) begin
            ctrl_q <= REG_WDATA_IN[2:0];
         end
      end
   end

   // one-second enable
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         div_q      <= 26'h000_0000;
         sec_tick_q <= 1'b0;
      end else if (div_q == 26'(SEC_CYCLES - 1)) begin
         div_q      <= 26'h000_0000;
         sec_tick_q <= 1'b1;
      end else begin
         div_q      <= div_q + 26'h000_0001;
         sec_tick_q <= 1'b0;
      end
   end

   idle_timer u_tx_idle (
      .clk_in      (CORE_CLK_IN),
      .rst_n_in    (RESET_N_IN),
      .sec_tick_in (sec_tick_q),
      .activity_in (TX_ACTIVITY_IN),
      .limit_in    (tx_idle_q),
      .alarm_out   (tx_alarm)
   ); // [R04]

   idle_timer u_rx_idle (
      .clk_in      (CORE_CLK_IN),
      .rst_n_in    (RESET_N_IN),
      .sec_tick_in (sec_tick_q),
      .activity_in (RX_ACTIVITY_IN),
      .limit_in    (rx_idle_q),
      .alarm_out   (rx_alarm)
   ); // [R05]

   // alarm routing
   logic [2:0] io_rt;
   logic [1:0] tx_rt;
   logic [1:0] rx_rt;
   logic [1:0] te_rt;
   logic [1:0] hw_rt;
   logic       io_act;
   assign io_rt  = route_q[F_IO_ROUTE +: 3];   // [R01]
   assign tx_rt  = route_q[F_TXD_ROUTE +: 2];  // [R02]
   assign rx_rt  = route_q[F_RXD_ROUTE +: 2];  // [R03]
   assign te_rt  = route_q[F_TEST_ROUTE +: 2]; // [R02]
   assign hw_rt  = route_q[F_HW_ROUTE +: 2];   // [R02]
   assign io_act = IO_ALARM_IN;

   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ALARM_A_OUT             <= 1'b0;
         ALARM_B_OUT             <= 1'b0;
         CARRIER_OUTPUT_MUTE_OUT <= 1'b0;
      end else begin
         ALARM_A_OUT <= (io_act & io_rt[0]) | (tx_alarm & tx_rt[0]) | (rx_alarm & rx_rt[0])
                      | (TEST_ACTIVE_IN & te_rt[0]) | (HW_ALARM_IN & hw_rt[0]); // [R14]
         ALARM_B_OUT <= (io_act & io_rt[1]) | (tx_alarm & tx_rt[1]) | (rx_alarm & rx_rt[1])
                      | (TEST_ACTIVE_IN & te_rt[1]) | (HW_ALARM_IN & hw_rt[1]); // [R14]
         CARRIER_OUTPUT_MUTE_OUT <= io_act & io_rt[2]; // [R01] [R14]
      end
   end

   // hardware alarm notification on each change of state
   logic [1:0] hw_notify;
   assign hw_notify = route_q[F_HW_NOTIFY +: 2];
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         hw_prev_q    <= 1'b0;
         HW_LOG_OUT   <= 1'b0;
         HW_ALERT_OUT <= 1'b0;
      end else begin
         hw_prev_q    <= HW_ALARM_IN;
         HW_LOG_OUT   <= (HW_ALARM_IN != hw_prev_q) && (hw_notify == 2'h1
                         || hw_notify == 2'h2); // [R13]
         HW_ALERT_OUT <= (HW_ALARM_IN != hw_prev_q) && hw_notify == 2'h2; // [R13]
      end
   end

   // loopbacks and coding select
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         SAT_SEND_OUT    <= 1'b0;
         LINE_RCV_OUT    <= 1'b0;
         CODING_HDB3_OUT <= 1'b0;
      end else begin
         SAT_SEND_OUT    <= ctrl_q[F_SAT_LOOP] ? SAT_RCV_IN : LINE_SEND_IN;   // [R06]
         LINE_RCV_OUT    <= ctrl_q[F_TER_LOOP] ? LINE_SEND_IN : SAT_RCV_IN;   // [R07]
         CODING_HDB3_OUT <= ctrl_q[F_CODING] == CODE_HDB3;                    // [R12]
      end
   end

   // handshake snapshot; shows zero while the channel is idle
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         hs_q <= 5'h00;
      end else begin
         hs_q <= AUXILIARY_SERIAL_CHANNEL_ACTIVE_IN ? HANDSHAKE_IN : 5'h00; // [R11]
      end
   end

   // per-port counters and receive buffer; clear loses to nothing: an error event in the clear cycle counts, a buffer write or read on recentre is dropped
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_port
         always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
            if (!RESET_N_IN) begin
               bpv_q[p] <= 16'h0000;
            end else if (cmd[F_CLR_BPV + p]) begin
               bpv_q[p] <= {15'h0000, BIPOLAR_VIOLATION_IN[p]}; // [R09]
            end else if (BIPOLAR_VIOLATION_IN[p] && bpv_q[p] != 16'hFFFF) begin
               bpv_q[p] <= bpv_q[p] + 16'h0001; // [R09]
            end
         end

         always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
            if (!RESET_N_IN) begin
               crc_q[p] <= 16'h0000;
            end else if (cmd[F_CLR_CRC + p]) begin
               crc_q[p] <= {15'h0000, CRC_ERROR_IN[p]}; // [R10]
            end else if (CRC_ERROR_IN[p] && crc_q[p] != 16'hFFFF) begin
               crc_q[p] <= crc_q[p] + 16'h0001; // [R10]
            end
         end

         // fill tracks writes minus reads; an over or underrun is a slip and re-centres
         logic wr_b;
         logic rd_b;
         logic over;
         logic under;
         assign wr_b  = BUF_WR_IN[p] & BUF_ACTIVE_IN[p];
         assign rd_b  = BUF_RD_IN[p] & BUF_ACTIVE_IN[p];
         assign over  = wr_b && !rd_b && fill_q[p] == 7'(BUF_DEPTH);
         assign under = rd_b && !wr_b && fill_q[p] == 7'h00;
         always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
            if (!RESET_N_IN) begin
               fill_q[p] <= BUF_CENTRE;
               slip_q[p] <= 16'h0000;
            end else if (cmd[F_RECENTRE + p] || !BUF_ACTIVE_IN[p]) begin
               fill_q[p] <= BUF_CENTRE; // [R08]
            end else if (over || under) begin
               fill_q[p] <= BUF_CENTRE;
               slip_q[p] <= (slip_q[p] == 16'hFFFF) ? slip_q[p] : slip_q[p] + 16'h0001; // [R08]
            end else if (wr_b && !rd_b) begin
               fill_q[p] <= fill_q[p] + 7'h01;
            end else if (rd_b && !wr_b) begin
               fill_q[p] <= fill_q[p] - 7'h01;
            end
         end
      end
   endgenerate

   // fill percent: centre (32 of 64) reads 100, full reads 200
   function automatic logic [7:0] fill_pct(input logic [6:0] f);
      logic [12:0] prod;
      prod = {6'h00, f} * 13'(PCT_CENTRE);
      return 8'(prod / 13'(BUF_CENTRE));
   endfunction

   // register reads, data one cycle after the strobe
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         REG_RDATA_OUT <= 32'h0000_0000;
      end else if (REG_RD_IN) begin
         if (REG_ADDR_IN == OFF_ROUTE) begin
            REG_RDATA_OUT <= route_q;
         end else if (REG_ADDR_IN == OFF_TX_IDLE) begin
            REG_RDATA_OUT <= {18'h0_0000, tx_idle_q};
         end else if (REG_ADDR_IN == OFF_RX_IDLE) begin
            REG_RDATA_OUT <= {18'h0_0000, rx_idle_q};
         end else if (REG_ADDR_IN == OFF_CTRL) begin
            REG_RDATA_OUT <= {29'h0000_0000, ctrl_q};
         end else if (REG_ADDR_IN == OFF_STATUS) begin
            REG_RDATA_OUT <= {16'h0000, 3'h0, AUXILIARY_SERIAL_CHANNEL_ACTIVE_IN, hs_q,
                              BUF_ACTIVE_IN, HW_ALARM_IN, TEST_ACTIVE_IN, rx_alarm,
                              tx_alarm, IO_ALARM_IN}; // [R11]
         end else if (REG_ADDR_IN == OFF_BUF0) begin
            REG_RDATA_OUT <= {slip_q[0], 8'h00, fill_pct(fill_q[0])}; // [R08]
         end else if (REG_ADDR_IN == OFF_BUF1) begin
            REG_RDATA_OUT <= {slip_q[1], 8'h00, fill_pct(fill_q[1])}; // [R08]
         end else if (REG_ADDR_IN == OFF_BPV0) begin
            REG_RDATA_OUT <= {16'h0000, bpv_q[0]};
         end else if (REG_ADDR_IN == OFF_BPV1) begin
            REG_RDATA_OUT <= {16'h0000, bpv_q[1]};
         end else if (REG_ADDR_IN == OFF_CRC0) begin
            REG_RDATA_OUT <= {16'h0000, crc_q[0]};
         end else if (REG_ADDR_IN == OFF_CRC1) begin
            REG_RDATA_OUT <= {16'h0000, crc_q[1]};
         end else if (REG_ADDR_IN == OFF_ID) begin
            REG_RDATA_OUT <= BLOCK_ID;
         end else begin
            REG_RDATA_OUT <= 32'h0000_0000;
         end
      end else begin
         REG_RDATA_OUT <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// file: testbench/e1_line_model.sv
// far-side model: line send data, satellite receive data, activity
// assumes one core clock; every line changes pattern each cycle
`default_nettype none
module e1_line_model (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   output logic      line_send_out,
   output logic      sat_rcv_out,
   output logic      tx_act_out,
   output logic      rx_act_out
);
   logic [7:0] lfsr_q;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lfsr_q <= 8'h5A;
      end else begin
         lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      end
   end
   // activity never pauses for a second, so idle alarms stay low
   assign line_send_out = lfsr_q[0];
   assign sat_rcv_out   = lfsr_q[3];
   assign tx_act_out    = lfsr_q[1] | lfsr_q[2];
   assign rx_act_out    = lfsr_q[4] | lfsr_q[6];
endmodule
`default_nettype wire

// file: testbench/e1_alarm_monitor_checker.sv
// port assertions for the e1 alarm monitor
// assumes route and control change only through register writes
`default_nettype none
module e1_alarm_monitor_checker
   import e1_alarm_pkg::*;
(
   input wire logic        CORE_CLK_IN, RESET_N_IN, REG_WR_IN, REG_RD_IN,
   input wire logic [7:0]  REG_ADDR_IN,
   input wire logic [31:0] REG_WDATA_IN, REG_RDATA_OUT,
   input wire logic        IO_ALARM_IN, TEST_ACTIVE_IN, HW_ALARM_IN, LINE_SEND_IN, SAT_RCV_IN,
   input wire logic        SAT_SEND_OUT, LINE_RCV_OUT, CODING_HDB3_OUT, ALARM_A_OUT,
   input wire logic        ALARM_B_OUT, CARRIER_OUTPUT_MUTE_OUT, HW_LOG_OUT, HW_ALERT_OUT
);
   logic [13:0] route_q;
   logic [2:0]  ctrl_q;
   logic [1:0]  age_q;
   wire         ok    = age_q[1];
   wire         a_src = IO_ALARM_IN & route_q[0] | TEST_ACTIVE_IN & route_q[8]
                        | HW_ALARM_IN & route_q[10];
   wire         b_src = IO_ALARM_IN & route_q[1] | TEST_ACTIVE_IN & route_q[9]
                        | HW_ALARM_IN & route_q[11];
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         route_q <= 14'h0000;
         ctrl_q  <= 3'h0;
      end else if (REG_WR_IN && REG_ADDR_IN == OFF_ROUTE) begin
         route_q <= {REG_WDATA_IN[13:4], 1'b0, REG_WDATA_IN[2:0]};
      end else if (REG_WR_IN && REG_ADDR_IN == OFF_CTRL) begin
         ctrl_q <= REG_WDATA_IN[2:0];
      end
   end
   // outputs are forced low on the first edge after release: skip the first two edges
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         age_q <= 2'h0;
      end else if (!age_q[1]) begin
         age_q <= age_q + 2'h1;
      end
   end
   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);
   a_alarm_a: assert property (ok |-> ALARM_A_OUT == $past(a_src))
      else $error("alarm A differs from routed sources");
   a_alarm_b: assert property (ok |-> ALARM_B_OUT == $past(b_src))
      else $error("alarm B differs from routed sources");
   a_carrier_mute: assert property (ok |->
      CARRIER_OUTPUT_MUTE_OUT == $past(IO_ALARM_IN & route_q[2]))
      else $error("carrier mute wrong");
   a_sat_loop: assert property (ok |->
      SAT_SEND_OUT == $past(ctrl_q[0] ? SAT_RCV_IN : LINE_SEND_IN))
      else $error("satellite send path wrong");
   a_ter_loop: assert property (ok |->
      LINE_RCV_OUT == $past(ctrl_q[1] ? LINE_SEND_IN : SAT_RCV_IN))
      else $error("line receive path wrong");
   a_coding_sel: assert property (ok && ctrl_q[2] == $past(ctrl_q[2])
      && ctrl_q[2] == $past(ctrl_q[2], 2) |-> CODING_HDB3_OUT == ctrl_q[2])
      else $error("line coding select wrong");
   a_hw_log: assert property (ok && $changed(HW_ALARM_IN) && route_q[13:12] inside {2'h1, 2'h2}
      |-> ##[1:2] HW_LOG_OUT)
      else $error("hardware alarm change not logged");
   a_hw_alert: assert property (ok && $changed(HW_ALARM_IN) && route_q[13:12] == 2'h2
      |-> ##[1:2] HW_ALERT_OUT)
      else $error("hardware alarm alert missing");
   a_hw_quiet: assert property (ok && route_q[13] == route_q[12]
      && $past(route_q[13:12]) == route_q[13:12] && $past(route_q[13:12], 2) == route_q[13:12]
      |-> !HW_LOG_OUT && !HW_ALERT_OUT)
      else $error("hardware alarm pulse without notify");
   c_mute: cover property (CARRIER_OUTPUT_MUTE_OUT);
   c_alert: cover property (HW_ALERT_OUT);
   c_sat_loop: cover property (ctrl_q[0] && SAT_RCV_IN);
   c_ter_loop: cover property (ctrl_q[1] && LINE_SEND_IN);
endmodule
bind e1_alarm_monitor e1_alarm_monitor_checker chk (.CORE_CLK_IN(CORE_CLK_IN),
   .RESET_N_IN(RESET_N_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
   .REG_ADDR_IN(REG_ADDR_IN),
   .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .IO_ALARM_IN(IO_ALARM_IN),
   .TEST_ACTIVE_IN(TEST_ACTIVE_IN), .HW_ALARM_IN(HW_ALARM_IN), .LINE_SEND_IN(LINE_SEND_IN),
   .SAT_RCV_IN(SAT_RCV_IN), .SAT_SEND_OUT(SAT_SEND_OUT), .LINE_RCV_OUT(LINE_RCV_OUT),
   .CODING_HDB3_OUT(CODING_HDB3_OUT), .ALARM_A_OUT(ALARM_A_OUT), .ALARM_B_OUT(ALARM_B_OUT),
   .CARRIER_OUTPUT_MUTE_OUT(CARRIER_OUTPUT_MUTE_OUT), .HW_LOG_OUT(HW_LOG_OUT),
   .HW_ALERT_OUT(HW_ALERT_OUT));
`default_nettype wire

// file: testbench/e1_interface_alarm_monitor_tb_top.sv
// self-checking bench for the e1 alarm monitor
// assumes the line model on the data pins and a 40 MHz core clock
`default_nettype none
module e1_interface_alarm_monitor_tb_top
   import e1_alarm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, wr, rd, io, tst, hw, auxiliary_serial_channel, l_snd, s_rcv, tx_act, rx_act, lv, sv;
   logic        sat_snd, line_rcv, hdb3, al_a, al_b, mute, hlog, halert;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic [13:0] route;
   logic [4:0]  hs;
   logic [2:0]  exp3;
   logic [1:0]  bipolar_violation, crc, bwr, brd, bact;
   integer      seed, errors, tests_run, i, n0, n1;
   e1_alarm_monitor dut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
      .IO_ALARM_IN(io), .TEST_ACTIVE_IN(tst), .HW_ALARM_IN(hw), .TX_ACTIVITY_IN(tx_act),
      .RX_ACTIVITY_IN(rx_act), .BIPOLAR_VIOLATION_IN(bipolar_violation), .CRC_ERROR_IN(crc), .BUF_WR_IN(bwr),
      .BUF_RD_IN(brd), .BUF_ACTIVE_IN(bact), .LINE_SEND_IN(l_snd), .SAT_RCV_IN(s_rcv),
      .SAT_SEND_OUT(sat_snd), .LINE_RCV_OUT(line_rcv), .CODING_HDB3_OUT(hdb3),
      .AUXILIARY_SERIAL_CHANNEL_ACTIVE_IN(auxiliary_serial_channel), .HANDSHAKE_IN(hs), .ALARM_A_OUT(al_a),
      .ALARM_B_OUT(al_b), .CARRIER_OUTPUT_MUTE_OUT(mute), .HW_LOG_OUT(hlog),
      .HW_ALERT_OUT(halert));
   e1_line_model far (.clk_in(clk), .rst_n_in(rst_n), .line_send_out(l_snd), .sat_rcv_out(s_rcv),
      .tx_act_out(tx_act), .rx_act_out(rx_act));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic conclude();
      if (errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      cmp32({31'h0, got}, {31'h0, exp});
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      cmp32(rdata & m, e);
   endtask
   task automatic pulse(input logic [1:0] b, input logic [1:0] c);
      @(posedge clk);
      bipolar_violation <= b;
      crc <= c;
      @(posedge clk);
      bipolar_violation <= 2'b00;
      crc <= 2'b00;
   endtask
   function automatic logic [2:0] alarm_exp(input logic [13:0] r, input logic a, t, h);
      alarm_exp = {a & r[2], a & r[1] | t & r[9] | h & r[11], a & r[0] | t & r[8] | h & r[10]};
   endfunction
   function automatic logic [31:0] stat_exp(input logic e, input logic [4:0] s,
                                            input logic h, t, a);
      stat_exp = {19'h0, e, e ? s : 5'h00, 2'b00, h, t, 2'b00, a};
   endfunction
   // percent of fill against the centre, which reads as 100
   function automatic logic [7:0] pct_exp(input logic [6:0] f);
      pct_exp = 8'((f * 16'(PCT_CENTRE)) / 16'(BUF_CENTRE));
   endfunction
   initial begin
      #2_000_000;
      errors++;
      conclude();
   end
   initial begin
      seed = 36772;
      errors = 0;
      tests_run = 0;
      {rst_n, wr, rd, io, tst, hw, auxiliary_serial_channel, hs, bipolar_violation, crc, bwr, brd, bact} = '0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      chk_reg(OFF_ROUTE, 32'hFFFF_FFFF, ROUTE_RESET);
      chk_reg(OFF_TX_IDLE, 32'hFFFF_FFFF, {18'h0, IDLE_RESET});
      chk_reg(OFF_ID, 32'hFFFF_FFFF, BLOCK_ID);
      chk_reg(8'hFC, 32'hFFFF_FFFF, 32'h0000_0000);
      chk_reg(OFF_BUF0, 32'hFFFF_FFFF, {24'h0, PCT_CENTRE});
      wr_reg(OFF_TX_IDLE, 32'h0000_FFFF);
      chk_reg(OFF_TX_IDLE, 32'hFFFF_FFFF, {18'h0, IDLE_MAX_SEC});
      wr_reg(OFF_RX_IDLE, 32'h0000_0000);
      chk_reg(OFF_RX_IDLE, 32'hFFFF_FFFF, 32'h0000_0000);
      for (i = 0; i < 24; i++) begin
         route = 14'($random(seed));
         route[2:0] = i[2:0];
         route[13:8] = {i[1:0], i[4:3], i[3:2]};
         wr_reg(OFF_ROUTE, {18'h0, route});
         @(posedge clk);
         {io, tst, hw, auxiliary_serial_channel, hs} <= 9'($random(seed));
         repeat (3) @(posedge clk);
         @(negedge clk);
         exp3 = alarm_exp(route, io, tst, hw);
         cmp1(al_a, exp3[0]);
         cmp1(al_b, exp3[1]);
         cmp1(mute, exp3[2]);
         chk_reg(OFF_STATUS, 32'hFFFF_FFFF, stat_exp(auxiliary_serial_channel, hs, hw, tst, io));
      end
      for (i = 0; i < 4; i++) begin
         wr_reg(OFF_CTRL, {29'h0, i[0] ^ i[1], i[1:0]});
         repeat (2) @(negedge clk);
         cmp1(hdb3, i[0] ^ i[1]);
         repeat (8) begin
            @(posedge clk);
            lv = l_snd;
            sv = s_rcv;
            @(negedge clk);
            cmp1(sat_snd, i[0] ? sv : lv);
            cmp1(line_rcv, i[1] ? lv : sv);
         end
      end
      n0 = {$random(seed)} % 7 + 1;
      n1 = {$random(seed)} % 7 + 1;
      for (i = 0; i < 8; i++) pulse({i < n1, i < n0}, {i < n0, i < n1});
      chk_reg(OFF_BPV0, 32'hFFFF_FFFF, n0);
      chk_reg(OFF_BPV1, 32'hFFFF_FFFF, n1);
      chk_reg(OFF_CRC1, 32'hFFFF_FFFF, n0);
      // clear port 0 violations and port 1 crc while a port 1 crc error lands
      @(posedge clk);
      {wr, addr, wdata, crc} <= {1'b1, OFF_CMD, 32'h0000_0009, 2'b10};
      @(posedge clk);
      {wr, crc} <= 3'b000;
      chk_reg(OFF_BPV0, 32'hFFFF_FFFF, 32'h0000_0000);
      chk_reg(OFF_BPV1, 32'hFFFF_FFFF, n1);
      chk_reg(OFF_CRC0, 32'hFFFF_FFFF, n1);
      chk_reg(OFF_CRC1, 32'hFFFF_FFFF, 32'h0000_0001);
      @(posedge clk);
      {bact, bwr} <= 4'b0101;
      repeat (40) @(posedge clk);
      bwr <= 2'b00;
      // 40 writes from centre: slip at the 33rd, then 7 more
      chk_reg(OFF_BUF0, 32'hFFFF_FFFF, {16'h0001, 8'h00, pct_exp(7'h27)});
      wr_reg(OFF_CMD, 32'h0000_0010);
      chk_reg(OFF_BUF0, 32'h0000_00FF, {24'h0, PCT_CENTRE});
      @(posedge clk);
      brd <= 2'b01;
      repeat (40) @(posedge clk);
      brd <= 2'b00;
      chk_reg(OFF_BUF0, 32'hFFFF_FFFF, {16'h0002, 8'h00, pct_exp(7'h19)});
      conclude();
   end
endmodule
`default_nettype wire
